// ---- bcrc_asserts.sv ----
// checker for the byte crc unit apb slave
// assumes it is bound to bcrc_top
`timescale 1ns/10ps
// ====
// port checks
module bcrc_asserts
(
	input wire clk_sys_i,
	input wire resetn_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [31:0] prdata_o,
	input wire pready_o,
	input wire pslverr_o
);
	default clocking @(posedge clk_sys_i);
	endclocking
	default disable iff (!resetn_i);
	wire su = psel_i && !penable_i;
	wire ok_a = paddr_i[11:4] == 8'h00 && paddr_i[1:0] == 2'h0;
	wire rdd = su && !pwrite_i && paddr_i == 12'h008;
	reg [7:0] fl_q;
	always @(posedge clk_sys_i or negedge resetn_i)
		if (!resetn_i)
			fl_q <= 8'h00;
		else if (su && pwrite_i && paddr_i == 12'h00C)
			fl_q <= {pwdata_i[0], pwdata_i[1], pwdata_i[2], pwdata_i[3],
				pwdata_i[4], pwdata_i[5], pwdata_i[6], pwdata_i[7]};
	property p_rdy; su |=> pready_o; endproperty
	a_rdy: assert property (p_rdy) else $error("no ready");
	property p_one; pready_o |=> !pready_o; endproperty
	a_one: assert property (p_one) else $error("ready held");
	property p_idle; !psel_i |=> !pready_o; endproperty
	a_idle: assert property (p_idle) else $error("stray ready");
	property p_err; su && !ok_a |=> pslverr_o && prdata_o == 32'h0; endproperty
	a_err: assert property (p_err) else $error("no error");
	property p_ok; su && ok_a |=> !pslverr_o; endproperty
	a_ok: assert property (p_ok) else $error("false error");
	property p_hi; rdd |=> prdata_o[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("wide byte");
	property p_flip; su && !pwrite_i && paddr_i == 12'h00C |=> prdata_o == {24'h0, fl_q};
	endproperty
	a_flip: assert property (p_flip) else $error("bad mirror");
	property p_init; su && pwrite_i && paddr_i == 12'h000 && pwdata_i[3] && pwdata_i[1:0] == 2'h0
		##3 rdd |=> prdata_o == {24'h0, {8{$past(pwdata_i[2], 4)}}}; endproperty
	a_init: assert property (p_init) else $error("bad start");
endmodule

// ---- bcrc_flip.v ----
// byte bit mirror
// assumes combinational use
`timescale 1ns/10ps
module bcrc_flip
(
	input wire [7:0] byte_i,
	output wire [7:0] byte_o
);
	genvar g;
	generate
		for (g = 0; g < 8; g = g + 1)
		begin : mirror
			assign byte_o[g] = byte_i[7 - g]; // RULE14
		end
	endgenerate
endmodule

// ---- bcrc_regs.vh ----
// constants for the byte crc unit: offsets, fields, reset values, polynomials
// assumes an apb slave with 32-bit data, one aligned word per register
// What this block does
// RULE1: input is a stream of bytes, each written to the input register
// RULE2: 16-bit mode is msb first with polynomial 0x1021
// RULE3: 16-bit mode xors each byte into the upper result byte first
// RULE4: 16-bit mode then does 8 left shifts, xoring poly when top bit set
// RULE5: 32-bit mode uses reflected 0x04C11DB7, bytes and result bit reversed
// RULE6: 32-bit mode xors each byte into the lowest result byte first
// RULE7: 32-bit mode does 8 right shifts, xoring 0xEDB88320 when low bit set
// RULE8: start value is all zeros or all ones, chosen by initial value select
// RULE9: width select 0 means 32-bit result, 1 means 16-bit result
// RULE10: writing 1 to initialize loads the chosen start value
// RULE11: result updates after every input byte with no further command
// RULE12: result byte access goes to the pointed byte, pointer then advances
// RULE13: result holds until reinitialized, overwritten or new input byte
// RULE14: bit reverse register reads back the written byte mirrored
// RULE15: pointer 0 is the low byte, wraps after the last active byte
`ifndef BCRC_REGS_VH
`define BCRC_REGS_VH
// =========================================
// register byte addresses
`define BCRC_ADDR_CTRL 12'h000
`define BCRC_ADDR_IN 12'h004
`define BCRC_ADDR_DAT 12'h008
`define BCRC_ADDR_FLIP 12'h00C
// =========================================
// control fields
`define BCRC_CTRL_PNT_LO 0
`define BCRC_CTRL_VAL 2
`define BCRC_CTRL_INIT 3
`define BCRC_CTRL_SEL 4
`define BCRC_CTRL_RESET 8'h00
// =========================================
// polynomials and start values
`define BCRC_POLY16 16'h1021
`define BCRC_POLY32_REFL 32'hEDB88320
`define BCRC_INIT_ONES 32'hFFFFFFFF
`define BCRC_INIT_ZERO 32'h00000000
`endif

// ---- bcrc_step.v ----
// one-byte crc update for both widths
// assumes a purely combinational use by the top
`timescale 1ns/10ps
`include "bcrc_regs.vh"
module bcrc_step
(
	input wire [31:0] crc_i,
	input wire [7:0] data_i,
	input wire width16_i,
	output wire [31:0] crc_o
);
	reg [15:0] c16;
	reg [31:0] c32;
	integer k;
	always @*
	begin
		c16 = crc_i[15:0] ^ {data_i, 8'h00}; // RULE3
		c32 = crc_i ^ {24'h000000, data_i}; // RULE6
		for (k = 0; k < 8; k = k + 1)
		begin
			if (c16[15]) // RULE4
				c16 = {c16[14:0], 1'b0} ^ `BCRC_POLY16; // RULE2
			else
				c16 = {c16[14:0], 1'b0};
			if (c32[0]) // RULE7
				c32 = {1'b0, c32[31:1]} ^ `BCRC_POLY32_REFL; // RULE5
			else
				c32 = {1'b0, c32[31:1]};
		end
	end
	assign crc_o = width16_i ? {16'h0000, c16} : c32; // RULE9
endmodule

// ---- bcrc_top.v ----
// byte crc unit with apb register slave
// assumes apb master on clk_sys_i, asynchronous active low reset
// pstrb_i is ignored; every write uses the low byte of pwdata_i
`timescale 1ns/10ps
`include "bcrc_regs.vh"
module bcrc_top
(
	input wire clk_sys_i,
	input wire resetn_i,
	input wire psel_i,
	input wire penable_i,
	input wire pwrite_i,
	input wire [11:0] paddr_i,
	input wire [31:0] pwdata_i,
	input wire [3:0] pstrb_i,
	output reg [31:0] prdata_o,
	output reg pready_o,
	output reg pslverr_o
);
	// =========================================
	// state and next values
	reg [31:0] result_q;
	reg [31:0] result_d;
	reg [1:0] result_byte_pointer_q;
	reg [1:0] result_byte_pointer_d;
	reg width_select_q;
	reg width_select_d;
	reg initial_value_select_q;
	reg initial_value_select_d;
	reg [7:0] bit_reverse_register_q;
	reg [7:0] bit_reverse_register_d;
	reg [31:0] rdata_d;
	reg err_d;

	// =========================================
	// datapath and decode nets
	wire [31:0] step_crc;
	wire [7:0] flipped;
	wire [31:0] lane_wdata;
	wire [7:0] lane_rdata;
	wire [3:0] lane_sel;
	wire [31:0] start_value;
	wire [1:0] last_ptr;
	wire [1:0] ptr_after;
	wire setup;
	wire wr;
	wire rd;
	wire mapped;
	wire wr_ctrl;
	wire wr_in;
	wire wr_dat;
	wire wr_flip;
	wire rd_ctrl;
	wire rd_dat;
	wire rd_flip;
	wire dat_access;
	wire init_req;

	// =========================================
	// control reset value
	localparam [7:0] CTRL_RESET = `BCRC_CTRL_RESET;

	// =========================================
	// functions
	function is_mapped;
		input [11:0] a;
		begin
			is_mapped = (a == `BCRC_ADDR_CTRL) || (a == `BCRC_ADDR_IN) ||
				(a == `BCRC_ADDR_DAT) || (a == `BCRC_ADDR_FLIP);
		end
	endfunction

	function [1:0] next_ptr;
		input [1:0] p;
		input [1:0] last;
		begin
			if (p >= last)
				next_ptr = 2'h0; // RULE15
			else
				next_ptr = p + 2'h1; // RULE12
		end
	endfunction

	function reg_hit;
		input [11:0] a;
		input [11:0] off;
		begin
			reg_hit = (a == off);
		end
	endfunction

	function [3:0] lane_onehot;
		input [1:0] p;
		begin
			case (p)
				2'h0: lane_onehot = 4'h1;
				2'h1: lane_onehot = 4'h2;
				2'h2: lane_onehot = 4'h4;
				default: lane_onehot = 4'h8;
			endcase
		end
	endfunction

	function [7:0] pick_byte;
		input [31:0] w;
		input [3:0] sel;
		integer i;
		begin
			pick_byte = 8'h00;
			for (i = 0; i < 4; i = i + 1)
			begin
				if (sel[i])
					pick_byte = w[8 * i +: 8];
			end
		end
	endfunction

	// =========================================
	// bus decode
	assign setup = psel_i && !penable_i;
	assign wr = setup && pwrite_i;
	assign rd = setup && !pwrite_i;
	assign mapped = is_mapped(paddr_i);
	assign wr_ctrl = wr && reg_hit(paddr_i, `BCRC_ADDR_CTRL);
	assign wr_in = wr && reg_hit(paddr_i, `BCRC_ADDR_IN); // RULE1
	assign wr_dat = wr && reg_hit(paddr_i, `BCRC_ADDR_DAT);
	assign wr_flip = wr && reg_hit(paddr_i, `BCRC_ADDR_FLIP);
	assign rd_ctrl = rd && reg_hit(paddr_i, `BCRC_ADDR_CTRL);
	assign rd_dat = rd && reg_hit(paddr_i, `BCRC_ADDR_DAT);
	assign rd_flip = rd && reg_hit(paddr_i, `BCRC_ADDR_FLIP);
	assign dat_access = wr_dat || rd_dat; // RULE12
	assign init_req = wr_ctrl && pwdata_i[`BCRC_CTRL_INIT]; // RULE10

	// =========================================
	// pointer and start value
	assign start_value = pwdata_i[`BCRC_CTRL_VAL] ? `BCRC_INIT_ONES : `BCRC_INIT_ZERO; // RULE8
	assign last_ptr = width_select_q ? 2'h1 : 2'h3; // RULE15
	assign ptr_after = next_ptr(result_byte_pointer_q, last_ptr);
	assign lane_sel = lane_onehot(result_byte_pointer_q);
	assign lane_rdata = pick_byte(result_q, lane_sel);

	// =========================================
	// byte lanes of the result
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : lane
			assign lane_wdata[8 * g +: 8] = lane_sel[g] ? pwdata_i[7:0] : result_q[8 * g +: 8];
		end
	endgenerate

	// =========================================
	// datapath
	bcrc_step i_bcrc_step
	(
		.crc_i(result_q),
		.data_i(pwdata_i[7:0]),
		.width16_i(width_select_q),
		.crc_o(step_crc)
	);

	bcrc_flip i_bcrc_flip
	(
		.byte_i(pwdata_i[7:0]),
		.byte_o(flipped)
	);

	// =========================================
	// next result
	always @*
	begin
		result_d = result_q; // RULE13
		if (init_req)
		begin
			result_d = start_value; // RULE10
		end
		else if (wr_in)
		begin
			result_d = step_crc; // RULE11
		end
		else if (wr_dat)
		begin
			result_d = lane_wdata; // RULE12
		end
	end

	// =========================================
	// next pointer
	always @*
	begin
		result_byte_pointer_d = result_byte_pointer_q;
		if (wr_ctrl)
		begin
			result_byte_pointer_d = pwdata_i[`BCRC_CTRL_PNT_LO + 1:`BCRC_CTRL_PNT_LO];
		end
		else if (dat_access)
		begin
			result_byte_pointer_d = ptr_after; // RULE12
		end
	end

	// =========================================
	// next control bits
	always @*
	begin
		width_select_d = width_select_q;
		initial_value_select_d = initial_value_select_q;
		if (wr_ctrl)
		begin
			width_select_d = pwdata_i[`BCRC_CTRL_SEL]; // RULE9
			initial_value_select_d = pwdata_i[`BCRC_CTRL_VAL]; // RULE8
		end
	end

	// =========================================
	// next bit reverse byte
	always @*
	begin
		bit_reverse_register_d = bit_reverse_register_q;
		if (wr_flip)
		begin
			bit_reverse_register_d = flipped; // RULE14
		end
	end

	// =========================================
	// read data and error
	always @*
	begin
		rdata_d = 32'h00000000;
		err_d = setup && !mapped;
		if (rd_ctrl)
		begin
			rdata_d[`BCRC_CTRL_SEL] = width_select_q;
			rdata_d[`BCRC_CTRL_VAL] = initial_value_select_q;
			rdata_d[`BCRC_CTRL_PNT_LO + 1:`BCRC_CTRL_PNT_LO] = result_byte_pointer_q;
		end
		else if (rd_dat)
		begin
			rdata_d[7:0] = lane_rdata; // RULE12
		end
		else if (rd_flip)
		begin
			rdata_d[7:0] = bit_reverse_register_q; // RULE14
		end
	end

	// =========================================
	// result register
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			result_q <= `BCRC_INIT_ZERO;
		end
		else
		begin
			result_q <= result_d;
		end
	end

	// =========================================
	// pointer register
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			result_byte_pointer_q <= CTRL_RESET[`BCRC_CTRL_PNT_LO + 1:`BCRC_CTRL_PNT_LO];
		end
		else
		begin
			result_byte_pointer_q <= result_byte_pointer_d;
		end
	end

	// =========================================
	// control register
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			width_select_q <= CTRL_RESET[`BCRC_CTRL_SEL];
			initial_value_select_q <= CTRL_RESET[`BCRC_CTRL_VAL];
		end
		else
		begin
			width_select_q <= width_select_d;
			initial_value_select_q <= initial_value_select_d;
		end
	end

	// =========================================
	// bit reverse register
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			bit_reverse_register_q <= 8'h00;
		end
		else
		begin
			bit_reverse_register_q <= bit_reverse_register_d;
		end
	end

	// =========================================
	// read data register; holds until the next setup
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			prdata_o <= 32'h00000000;
		end
		else if (setup)
		begin
			prdata_o <= rdata_d;
		end
	end

	// =========================================
	// ready: work happens in the setup cycle, answer in the access cycle
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pready_o <= 1'b0;
		end
		else
		begin
			pready_o <= setup;
		end
	end

	// =========================================
	// error flag for unmapped addresses
	always @(posedge clk_sys_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			pslverr_o <= 1'b0;
		end
		else
		begin
			pslverr_o <= err_d;
		end
	end
endmodule

// ---- bcrc_top_tb.sv ----
// testbench for the byte crc unit over apb
// assumes bcrc_top and bcrc_asserts compiled first
`timescale 1ns/10ps
// ====
// bench top
module bcrc_top_tb;
	reg clk_sys_i = 0;
	reg resetn_i = 0;
	reg psel_i = 0;
	reg penable_i = 0;
	reg pwrite_i = 0;
	reg [11:0] paddr_i = 12'h000;
	reg [31:0] pwdata_i = 32'h0;
	wire [31:0] prdata_o;
	wire pready_o;
	wire pslverr_o;
	reg [31:0] rd_q;
	reg err_q;
	int bad_count = 0;
	int compares = 0;
	bcrc_top i_bcrc_top(.clk_sys_i, .resetn_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
		.pwdata_i, .pstrb_i(4'hF), .prdata_o, .pready_o, .pslverr_o);
	initial
	begin
		forever #2 clk_sys_i = ~clk_sys_i;
	end
	task complete_run;
		if (bad_count == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task xfer(input [11:0] a, input w, input [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1)
			@(posedge clk_sys_i);
		rd_q = prdata_o;
		err_q = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task crc(input [4:0] ctl, input [39:0] din, input int n, input [31:0] exp, input int nb);
		xfer(12'h000, 1'b1, {27'h0, ctl});
		for (int i = 0; i < n; i++)
			xfer(12'h004, 1'b1, {24'h0, din[8*i +: 8]});
		for (int i = 0; i <= nb; i++)
		begin
			xfer(12'h008, 1'b0, 32'h0);
			chk(rd_q, {24'h0, exp[8*(i % nb) +: 8]});
		end
	endtask
	initial
	begin
		repeat (4000) @(posedge clk_sys_i);
		bad_count++;
		complete_run;
	end
	initial
	begin
		repeat (12) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		@(posedge clk_sys_i);
		crc(5'h0C, 40'h63, 1, 32'hF9462090, 4);
		crc(5'h0C, 40'hCCBBAA0000, 5, 32'h78D129BC, 4);
		crc(5'h1C, 40'h63, 1, 32'hBD35, 2);
		crc(5'h1C, 40'hCCBBAA, 3, 32'h6CF6, 2);
		crc(5'h08, 40'h0, 0, 32'h0, 4);
		crc(5'h0C, 40'h0, 0, 32'hFFFFFFFF, 4);
		xfer(12'h000, 1'b1, 32'h1F);
		xfer(12'h000, 1'b0, 32'h0);
		chk(rd_q, 32'h17);
		xfer(12'h008, 1'b0, 32'h0);
		chk(rd_q, 32'hFF);
		xfer(12'h000, 1'b0, 32'h0);
		chk(rd_q, 32'h14);
		xfer(12'h000, 1'b1, 32'h01);
		xfer(12'h008, 1'b1, 32'h5A);
		xfer(12'h000, 1'b1, 32'h01);
		xfer(12'h008, 1'b0, 32'h0);
		chk(rd_q, 32'h5A);
		xfer(12'h000, 1'b0, 32'h0);
		chk(rd_q, 32'h02);
		xfer(12'h00C, 1'b1, 32'hC0);
		xfer(12'h00C, 1'b0, 32'h0);
		chk(rd_q, 32'h03);
		xfer(12'h010, 1'b0, 32'h0);
		chk({rd_q[30:0], err_q}, 32'h1);
		complete_run;
	end
endmodule
bind bcrc_top bcrc_asserts i_bcrc_asserts(.clk_sys_i, .resetn_i, .psel_i, .penable_i,
	.pwrite_i, .paddr_i, .pwdata_i, .prdata_o, .pready_o, .pslverr_o);
